// file: src/cfsp_regs.svh
`ifndef CFSP_REGS_SVH
`define CFSP_REGS_SVH

// ---------------------------------------------------------------
// Condition flag field positions
// ---------------------------------------------------------------
`define CFSP_CC_H 4
`define CFSP_CC_I 3
`define CFSP_CC_N 2
`define CFSP_CC_Z 1
`define CFSP_CC_C 0
`define CFSP_CC_FIXED 8'hE0
`define CFSP_CC_RESET 8'hE8

// ---------------------------------------------------------------
// Stack pointer layout
// ---------------------------------------------------------------
`define CFSP_SP_LOW_W 6
`define CFSP_SP_FIXED 16'h0140
`define CFSP_SP_RESET 16'h017F
`define CFSP_STK_DEPTH 64

// ---------------------------------------------------------------
// Context sequence lengths (last byte index)
// ---------------------------------------------------------------
`define CFSP_INT_LAST 3'h4
`define CFSP_CALL_LAST 3'h1

`endif

// file: src/cfsp_pkg.sv
package cfsp_pkg;

  // ALU result class
  typedef enum logic [2:0] {
    CFSP_ALU_LOGIC,
    CFSP_ALU_ADD,
    CFSP_ALU_SUB,
    CFSP_ALU_SHIFT,
    CFSP_ALU_BTEST
  } cfsp_alu_kind_type;

  // Dedicated flag instructions
  typedef enum logic [2:0] {
    CFSP_FLG_NONE,
    CFSP_FLG_SET_CARRY,
    CFSP_FLG_CLEAR_CARRY,
    CFSP_FLG_SET_MASK,
    CFSP_FLG_UNMASK
  } cfsp_flag_cmd_type;

  // Single stack instructions
  typedef enum logic [2:0] {
    CFSP_STK_NONE,
    CFSP_STK_PUSH,
    CFSP_STK_POP,
    CFSP_STK_REINIT,
    CFSP_STK_LOAD_LOW
  } cfsp_stk_cmd_type;

  // Context save and restore sequences
  typedef enum logic [2:0] {
    CFSP_CTX_NONE,
    CFSP_CTX_CALL,
    CFSP_CTX_INT_ENTRY,
    CFSP_CTX_SUB_RETURN,
    CFSP_CTX_INT_RETURN
  } cfsp_ctx_cmd_type;

  typedef enum logic [1:0] {
    CFSP_ST_IDLE,
    CFSP_ST_PUSH,
    CFSP_ST_POP
  } cfsp_state_type;

endpackage

// file: src/cfsp_flags_stack.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfsp_regs.svh"

// What this block does
// - Half carry follows the carry from bit 3 into bit 4 on add.
// - Mask set on interrupt entry or by software; blocks every interrupt request.
// - Requests arriving while masked stay pending until mask clears.
// - Interrupt return restores the mask cleared by popping flags.
// - Clearing the mask in a service routine releases pending requests.
// - Negative flag takes result bit 7 after every data operation except bit test.
// - Zero flag is 1 for an all-zero result, else 0.
// - Carry from arithmetic, set/clear instructions, bit test, shifts.
// - Flags register is 8 bits, upper three read 1, H I N Z C below.
// - Whole flags register can be pushed or popped; only carry and mask bits set singly.
// - Pointer marks next free byte; decrement after push, pop pre-inc.
// - Upper ten pointer bits fixed; reset and reinit load top of stack.
// - Pointer wraps silently at both stack limits.
// - Interrupt pushes five bytes starting with low PC; call pushes two.
// - Low six pointer bits are loadable and readable directly.
// - Second index register is never part of automatic context.
// - Program counter is 16 bits, stacked as separate low/high bytes.
module cfsp_flags_stack (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // ALU result
  input wire logic alu_we,
  input wire cfsp_pkg::cfsp_alu_kind_type alu_kind,
  input wire logic [7:0] alu_result,
  input wire logic alu_half_carry,
  input wire logic alu_carry,
  // Flag instructions
  input wire cfsp_pkg::cfsp_flag_cmd_type flag_cmd,
  // Single stack instructions
  input wire cfsp_pkg::cfsp_stk_cmd_type stk_cmd,
  input wire logic [7:0] stk_wdata,
  input wire logic stk_use_cc,
  // Context sequences
  input wire cfsp_pkg::cfsp_ctx_cmd_type ctx_cmd,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] x_in,
  // Interrupt requests
  input wire logic irq_req,
  input wire logic irq_ack,
  // Register views
  output logic [7:0] condition_flags_q,
  output logic [15:0] stack_top_pointer_q,
  // Stack read data
  output logic [7:0] stk_rdata_q,
  output logic stk_rvalid_q,
  // Restored context
  output logic [15:0] ctx_pc_q,
  output logic [7:0] ctx_acc_q,
  output logic [7:0] ctx_x_q,
  output logic ctx_done_q,
  output logic busy_q,
  // Interrupt service
  output logic irq_take_q
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] ctx_byte(
    input logic [2:0] idx,
    input logic [15:0] pc,
    input logic [7:0] acc,
    input logic [7:0] x,
    input logic [7:0] cc
  );
    case (idx)
      3'h0: ctx_byte = pc[7:0];
      3'h1: ctx_byte = pc[15:8];
      3'h2: ctx_byte = x;
      3'h3: ctx_byte = acc;
      default: ctx_byte = cc;
    endcase
  endfunction

  function automatic logic is_cmd(
    input cfsp_pkg::cfsp_stk_cmd_type cmd,
    input cfsp_pkg::cfsp_stk_cmd_type want
  );
    is_cmd = (cmd == want);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cfsp_pkg::cfsp_state_type state_q;
  cfsp_pkg::cfsp_state_type state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] last_q;
  logic [2:0] last_d;
  logic is_int_q;
  logic [15:0] cap_pc_q;
  logic [7:0] cap_acc_q;
  logic [7:0] cap_x_q;
  logic pend_q;
  logic [7:0] mem_q [`CFSP_STK_DEPTH];

  wire idle = (state_q == cfsp_pkg::CFSP_ST_IDLE);
  wire seq_push = (state_q == cfsp_pkg::CFSP_ST_PUSH);
  wire seq_pop = (state_q == cfsp_pkg::CFSP_ST_POP);
  wire ctx_start = idle && (ctx_cmd != cfsp_pkg::CFSP_CTX_NONE);
  wire ctx_is_push = (ctx_cmd == cfsp_pkg::CFSP_CTX_CALL) ||
                     (ctx_cmd == cfsp_pkg::CFSP_CTX_INT_ENTRY);
  wire ctx_is_int = (ctx_cmd == cfsp_pkg::CFSP_CTX_INT_ENTRY) ||
                    (ctx_cmd == cfsp_pkg::CFSP_CTX_INT_RETURN);
  wire single_ok = idle && !ctx_start;
  wire one_push = single_ok && is_cmd(stk_cmd, cfsp_pkg::CFSP_STK_PUSH);
  wire one_pop = single_ok && is_cmd(stk_cmd, cfsp_pkg::CFSP_STK_POP);
  wire reinit = single_ok && is_cmd(stk_cmd, cfsp_pkg::CFSP_STK_REINIT);
  wire load_low = single_ok && is_cmd(stk_cmd, cfsp_pkg::CFSP_STK_LOAD_LOW);
  wire seq_end = (seq_push && (cnt_q == last_q)) ||
                 (seq_pop && (cnt_q == 3'h0));

  // ---------------------------------------------------------------
  // Stack pointer
  // ---------------------------------------------------------------
  wire [`CFSP_SP_LOW_W-1:0] sp_lo = stack_top_pointer_q[`CFSP_SP_LOW_W-1:0];
  wire [`CFSP_SP_LOW_W-1:0] sp_dec = sp_lo - 6'h01;
  wire [`CFSP_SP_LOW_W-1:0] sp_inc = sp_lo + 6'h01;
  wire push_go = seq_push || one_push;
  wire pop_go = seq_pop || one_pop;
  wire [15:0] sp_fixed = `CFSP_SP_FIXED;
  wire [15:0] sp_d =
    reinit ? `CFSP_SP_RESET :
    load_low ? {sp_fixed[15:6], stk_wdata[5:0]} :
    push_go ? {sp_fixed[15:6], sp_dec} :
    pop_go ? {sp_fixed[15:6], sp_inc} :
    stack_top_pointer_q;

  wire [7:0] push_byte = seq_push ?
    ctx_byte(cnt_q, cap_pc_q, cap_acc_q, cap_x_q, condition_flags_q) :
    (stk_use_cc ? condition_flags_q : stk_wdata);
  wire [7:0] pop_byte = mem_q[sp_inc];

  // ---------------------------------------------------------------
  // Condition flags next value
  // ---------------------------------------------------------------
  wire cc_pop_load = (seq_pop && (cnt_q == `CFSP_INT_LAST)) ||
                     (one_pop && stk_use_cc);
  wire alu_add = alu_we && (alu_kind == cfsp_pkg::CFSP_ALU_ADD);
  wire alu_nz = alu_we && (alu_kind != cfsp_pkg::CFSP_ALU_BTEST);
  wire alu_c = alu_we && (alu_kind != cfsp_pkg::CFSP_ALU_LOGIC);
  wire int_mask_set = seq_push && is_int_q && (cnt_q == last_q);
  wire set_c = (flag_cmd == cfsp_pkg::CFSP_FLG_SET_CARRY);
  wire clr_c = (flag_cmd == cfsp_pkg::CFSP_FLG_CLEAR_CARRY);
  wire set_i = (flag_cmd == cfsp_pkg::CFSP_FLG_SET_MASK);
  wire clr_i = (flag_cmd == cfsp_pkg::CFSP_FLG_UNMASK);

  wire h_d = alu_add ? alu_half_carry :
             condition_flags_q[`CFSP_CC_H];
  wire i_d = (int_mask_set || set_i) ? 1'b1 :
             clr_i ? 1'b0 :
             condition_flags_q[`CFSP_CC_I];
  wire n_d = alu_nz ? alu_result[7] :
             condition_flags_q[`CFSP_CC_N];
  wire z_d = alu_nz ? (alu_result == 8'h00) :
             condition_flags_q[`CFSP_CC_Z];
  wire c_d = alu_c ? alu_carry :
             set_c ? 1'b1 :
             clr_c ? 1'b0 :
             condition_flags_q[`CFSP_CC_C];

  wire [7:0] cc_upd = {3'h7, h_d, i_d, n_d, z_d, c_d};
  wire [7:0] cc_d = cc_pop_load ? (pop_byte | `CFSP_CC_FIXED) : cc_upd;

  // ---------------------------------------------------------------
  // Interrupt pending
  // ---------------------------------------------------------------
  wire pend_d = irq_req || (pend_q && !irq_ack);
  wire take_d = pend_d && !cc_d[`CFSP_CC_I] && idle;

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    last_d = last_q;
    case (state_q)
      cfsp_pkg::CFSP_ST_IDLE: begin
        if (ctx_start) begin
          last_d = ctx_is_int ? `CFSP_INT_LAST : `CFSP_CALL_LAST;
          if (ctx_is_push) begin
            state_d = cfsp_pkg::CFSP_ST_PUSH;
            cnt_d = 3'h0;
          end else begin
            state_d = cfsp_pkg::CFSP_ST_POP;
            cnt_d = ctx_is_int ? `CFSP_INT_LAST : `CFSP_CALL_LAST;
          end
        end
      end
      cfsp_pkg::CFSP_ST_PUSH: begin
        if (seq_end) begin
          state_d = cfsp_pkg::CFSP_ST_IDLE;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      cfsp_pkg::CFSP_ST_POP: begin
        if (seq_end) begin
          state_d = cfsp_pkg::CFSP_ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: begin
        state_d = cfsp_pkg::CFSP_ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Stack storage
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `CFSP_STK_DEPTH; g++) begin : g_mem
    wire we = push_go && (sp_lo == 6'(g));
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_q[g] <= 8'h00;
      end else if (clk_en && we) begin
        mem_q[g] <= push_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      condition_flags_q <= `CFSP_CC_RESET;
      stack_top_pointer_q <= `CFSP_SP_RESET;
      pend_q <= 1'b0;
      irq_take_q <= 1'b0;
    end else if (clk_en) begin
      condition_flags_q <= cc_d;
      stack_top_pointer_q <= sp_d;
      pend_q <= pend_d;
      irq_take_q <= take_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= cfsp_pkg::CFSP_ST_IDLE;
      cnt_q <= 3'h0;
      last_q <= 3'h0;
      is_int_q <= 1'b0;
      busy_q <= 1'b0;
      ctx_done_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      is_int_q <= ctx_start ? ctx_is_int : is_int_q;
      busy_q <= (state_d != cfsp_pkg::CFSP_ST_IDLE);
      ctx_done_q <= seq_end;
    end
  end

  // Context capture at start; the second index register is never taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_pc_q <= 16'h0000;
      cap_acc_q <= 8'h00;
      cap_x_q <= 8'h00;
    end else if (clk_en && ctx_start && ctx_is_push) begin
      cap_pc_q <= pc_in;
      cap_acc_q <= acc_in;
      cap_x_q <= x_in;
    end
  end

  // Restored context, one byte per pop step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx_pc_q <= 16'h0000;
      ctx_acc_q <= 8'h00;
      ctx_x_q <= 8'h00;
    end else if (clk_en && seq_pop) begin
      case (cnt_q)
        3'h0: ctx_pc_q[7:0] <= pop_byte;
        3'h1: ctx_pc_q[15:8] <= pop_byte;
        3'h2: ctx_x_q <= pop_byte;
        3'h3: ctx_acc_q <= pop_byte;
        default: ctx_pc_q <= ctx_pc_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stk_rdata_q <= 8'h00;
      stk_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      stk_rvalid_q <= one_pop;
      if (one_pop) begin
        stk_rdata_q <= pop_byte;
      end
    end
  end

endmodule

`default_nettype wire

// file: dv/cfsp_alu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfsp_alu_model (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire cfsp_pkg::cfsp_alu_kind_type kind,
  // Result
  output logic [7:0] res,
  output logic hc,
  output logic cy
);
  always_comb begin
    hc = (a[3:0] + b[3:0]) > 5'h0F;
    {cy, res} = {1'b0, a & b};
    case (kind)
      cfsp_pkg::CFSP_ALU_ADD: {cy, res} = a + b;
      cfsp_pkg::CFSP_ALU_SUB: {cy, res} = a - b;
      cfsp_pkg::CFSP_ALU_SHIFT: {cy, res} = {a, 1'b0};
      cfsp_pkg::CFSP_ALU_BTEST: cy = a[b[2:0]];
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// file: dv/cfsp_flags_stack_props.sv
`timescale 1ns/1ps
`default_nettype none
module cfsp_flags_stack_props (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Requests
  input wire logic alu_we,
  input wire cfsp_pkg::cfsp_alu_kind_type alu_kind,
  input wire logic [7:0] alu_result,
  input wire logic alu_half_carry,
  input wire cfsp_pkg::cfsp_stk_cmd_type stk_cmd,
  input wire logic stk_use_cc,
  input wire cfsp_pkg::cfsp_ctx_cmd_type ctx_cmd,
  // Results
  input wire logic [7:0] condition_flags_q,
  input wire logic [15:0] stack_top_pointer_q,
  input wire logic busy_q,
  input wire logic ctx_done_q,
  input wire logic irq_take_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire rdy_w = clk_en && !busy_q;
  wire stk_w = rdy_w && ctx_cmd == cfsp_pkg::CFSP_CTX_NONE;
  // Popped flags override an ALU write in the same cycle
  wire alu_w = rdy_w && alu_we &&
    !(stk_use_cc && stk_cmd == cfsp_pkg::CFSP_STK_POP);
  wire bt_w = alu_kind == cfsp_pkg::CFSP_ALU_BTEST;
  wire add_w = alu_kind == cfsp_pkg::CFSP_ALU_ADD;
  wire [5:0] lo_w = stack_top_pointer_q[5:0];

  chk_fixed_bits: assert property (condition_flags_q[7:5] == 3'h7)
    else $error("flag upper bits wrong");
  chk_sp_upper: assert property (
    stack_top_pointer_q[15:6] == 10'h005)
    else $error("pointer upper bits wrong");
  chk_zero_flag: assert property (alu_w && !bt_w |=>
    condition_flags_q[1] == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  chk_neg_flag: assert property (alu_w && !bt_w |=>
    condition_flags_q[2] == $past(alu_result[7]))
    else $error("negative flag wrong");
  chk_half_carry: assert property (alu_w && add_w |=>
    condition_flags_q[4] == $past(alu_half_carry))
    else $error("half carry wrong");
  chk_reinit_top: assert property (stk_w &&
    stk_cmd == cfsp_pkg::CFSP_STK_REINIT |=> stack_top_pointer_q == 16'h017F)
    else $error("reinit pointer wrong");
  chk_push_dec: assert property (stk_w &&
    stk_cmd == cfsp_pkg::CFSP_STK_PUSH |=> lo_w == $past(lo_w) - 6'h01)
    else $error("push pointer wrong");
  chk_call_two: assert property (rdy_w &&
    ctx_cmd == cfsp_pkg::CFSP_CTX_CALL |-> ##3 ctx_done_q &&
    lo_w == $past(lo_w, 3) - 6'h02)
    else $error("call sequence wrong");
  chk_int_entry: assert property (rdy_w &&
    ctx_cmd == cfsp_pkg::CFSP_CTX_INT_ENTRY |-> ##6 ctx_done_q &&
    condition_flags_q[3] && lo_w == $past(lo_w, 6) - 6'h05)
    else $error("interrupt entry wrong");
  // Take and flags load from the same next values, so compare them together
  chk_irq_masked: assert property (irq_take_q && $past(clk_en) |->
    !condition_flags_q[3] && !$past(busy_q))
    else $error("interrupt taken while masked");
endmodule
`default_nettype wire

// file: dv/cfsp_flags_stack_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cfsp_flags_stack_tb_top;
  logic clk = 0, arst_n = 0, clk_en = 1, we = 0, cc = 0, irq = 0, ack = 0;
  logic [2:0] k = 0, f = 0, s = 0, c = 0;
  logic [7:0] a = 0, b = 0, wd = 0, acc = 0, xr = 0, ef = 8'hE8, sv;
  logic [7:0] res, fl, rd, ca, cx, mem [64], q [$];
  logic [15:0] pc = 0, sp, cpc;
  logic hc, cy, rv, done, busy, take;
  logic [5:0] esp = 6'h3F;
  int err_count = 0, checked = 0, seed = 95, cycles = 0;

  cfsp_alu_model pm_u (.a(a), .b(b), .kind(cfsp_pkg::cfsp_alu_kind_type'(k)),
    .res(res), .hc(hc), .cy(cy));
  cfsp_flags_stack dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .alu_we(we), .alu_kind(cfsp_pkg::cfsp_alu_kind_type'(k)),
    .alu_result(res), .alu_half_carry(hc), .alu_carry(cy),
    .flag_cmd(cfsp_pkg::cfsp_flag_cmd_type'(f)),
    .stk_cmd(cfsp_pkg::cfsp_stk_cmd_type'(s)), .stk_wdata(wd),
    .stk_use_cc(cc), .ctx_cmd(cfsp_pkg::cfsp_ctx_cmd_type'(c)),
    .pc_in(pc), .acc_in(acc), .x_in(xr), .irq_req(irq), .irq_ack(ack),
    .condition_flags_q(fl), .stack_top_pointer_q(sp), .stk_rdata_q(rd),
    .stk_rvalid_q(rv), .ctx_pc_q(cpc), .ctx_acc_q(ca), .ctx_x_q(cx),
    .ctx_done_q(done), .busy_q(busy), .irq_take_q(take));

  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic go(input logic w, input logic [2:0] fc, sc, xc);
    we = w;
    f = fc;
    s = sc;
    c = xc;
    @(posedge clk);
    #1;
  endtask
  task automatic push(input logic [7:0] v);
    wd = v;
    go(0, 0, 1, 0);
    mem[esp] = v;
    esp--;
    cmp(sp, {10'h005, esp});
    cmp(rv, 0);
  endtask
  task automatic pop();
    go(0, 0, 2, 0);
    esp++;
    if (cc) ef = mem[esp];
    else cmp(rd, mem[esp]);
    cmp(rv, 1);
    cmp(sp, {10'h005, esp});
  endtask
  task automatic ctx(input logic [2:0] cmd);
    go(0, 0, 0, cmd);
    cmp(busy, 1);
    wd = 8'h5A;
    // Push offered while busy must be ignored
    go(0, 0, 1, 0);
    for (int i = 0; i < 8 && done !== 1'b1; i++) go(0, 0, 0, 0);
    cmp(done, 1);
    cmp(busy, 0);
  endtask
  task automatic ent();
    pc = 16'($random(seed));
    acc = 8'($random(seed));
    xr = 8'($random(seed));
    go(0, 4, 0, 0);
    ef[3] = 0;
    sv = ef;
    ctx(2);
    q = {pc[7:0], pc[15:8], xr, acc, ef};
    foreach (q[i]) begin
      mem[esp] = q[i];
      esp--;
    end
    ef[3] = 1;
    cmp(fl, ef);
    cmp(sp, {10'h005, esp});
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1;
    cmp(fl, 8'hE8);
    cmp(sp, 16'h017F);
    for (int i = 0; i < 40; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      k = 3'(i % 5);
      go(1, 0, 0, 0);
      if (k != 4) begin
        ef[2] = res[7];
        ef[1] = res == 8'h00;
      end
      if (k != 0) ef[0] = cy;
      if (k == 1) ef[4] = hc;
      cmp(fl, ef);
    end
    for (int i = 1; i < 5; i++) begin
      go(0, 3'(i), 0, 0);
      if (i < 3) ef[0] = i == 1;
      else ef[3] = i == 3;
      cmp(fl, ef);
    end
    cc = 1;
    push(ef);
    go(0, 1, 0, 0);
    pop();
    cc = 0;
    cmp(fl, ef);
    ent();
    repeat (5) pop();
    ent();
    ctx(4);
    esp = esp + 6'h05;
    ef = sv;
    cmp(fl, ef);
    cmp(fl[3], 0);
    cmp(cpc, pc);
    cmp(ca, acc);
    cmp(cx, xr);
    cmp(sp, {10'h005, esp});
    pc = 16'($random(seed));
    ctx(1);
    esp = esp - 6'h02;
    cmp(sp, {10'h005, esp});
    ctx(3);
    esp = esp + 6'h02;
    cmp(cpc, pc);
    for (int i = 0; i < 64; i++) push(8'($random(seed)));
    repeat (2) pop();
    wd = 8'($random(seed));
    go(0, 0, 4, 0);
    esp = wd[5:0];
    cmp(sp, {10'h005, esp});
    go(0, 0, 3, 0);
    cmp(sp, 16'h017F);
    clk_en = 0;
    go(0, 0, 1, 0);
    cmp(sp, 16'h017F);
    clk_en = 1;
    go(0, 3, 0, 0);
    irq = 1;
    go(0, 0, 0, 0);
    irq = 0;
    go(0, 0, 0, 0);
    cmp(take, 0);
    go(0, 4, 0, 0);
    go(0, 0, 0, 0);
    cmp(take, 1);
    ack = 1;
    go(0, 0, 0, 0);
    ack = 0;
    go(0, 0, 0, 0);
    cmp(take, 0);
    stop_test();
  end
endmodule

bind cfsp_flags_stack cfsp_flags_stack_props chk_u (.clk, .arst_n, .clk_en,
  .alu_we, .alu_kind, .alu_result, .alu_half_carry, .stk_cmd, .stk_use_cc,
  .ctx_cmd, .condition_flags_q, .stack_top_pointer_q, .busy_q, .ctx_done_q,
  .irq_take_q);
`default_nettype wire
